// file: hdl/atc_params.svh
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH
// Frame layout
`define ATC_CMD_CODE 8'h1D
`define ATC_FRAME_LEN 4'hB
`define ATC_POS_PARAM1 4'h5
`define ATC_POS_PARAM2 4'h6
`define ATC_POS_PARAM3 4'h7
`define ATC_POS_PARAM4 4'h8
// Parameter values
`define ATC_PROTO_TYPE 4'h1
`define ATC_PARAM3_OK 8'h01
`define ATC_REPLY_CODE 8'h10
`define ATC_RATE_106 2'h0
`define ATC_RATE_212 2'h1
`define ATC_TR_RSVD 2'h3
`define ATC_TR_DEFAULT 2'h0
// Fixed operating timing, in 1/fs units
`define ATC_TR0_FIXED 8'h40
`define ATC_TR1_FIXED 8'h50
`endif

// file: hdl/atc_pkg.sv
`default_nettype none
package atc_pkg;
   typedef enum logic [1:0] {ATC_IDLE = 2'b00, ATC_RECV = 2'b01, ATC_DONE = 2'b11, ATC_SKIP = 2'b10} atc_state_t;
endpackage
`default_nettype wire

// file: hdl/atc_attrib_handler.sv
// Behaviour
// (RULE_01) Frame: 1D, ident4, params4, CRC2
// (RULE_02) Accepted ATTRIB enables command processing
// (RULE_03) Param1 bits 7-6 request TR0
// (RULE_04) Param1 bits 5-4 request TR1
// (RULE_05) Reserved 11b TR code means 00b
// (RULE_06) Always TR0 64, TR1 80, delimiters
// (RULE_07) Param1 bits 3-2 request delimiter omission
// (RULE_08) Unequal data rates give silence
// (RULE_09) Param2 low nibble gives reader frame size
// (RULE_10) Unsupported rate or size gives silence
// (RULE_11) Param3 must equal 0x01
// (RULE_12) Param4 low nibble must be zero
// (RULE_13) Bad CRC frame is not acted on
// (RULE_14) Advertised protocol type is 0001b
// (RULE_15) Accept reply is byte 0x10
// (RULE_16) Identifier must match stored PUPI
// (RULE_17) Rejection keeps previous protocol state
`timescale 1ns/1ns
`default_nettype none
`include "atc_params.svh"
module atc_attrib_handler
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Received byte stream from the demodulator
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_sof,
   // End of frame with CRC verdict
   input wire logic rx_eof,
   input wire logic rx_crc_ok,
   // Stored identifier
   input wire logic [31:0] pupi,
   // Protocol state
   output logic cmd_enable_reg,
   // Reply request to the frame builder
   output logic reply_req_reg,
   output logic [7:0] reply_byte_reg,
   // Negotiated settings, then the fixed timing and delimiter settings
   output logic [1:0] rate_reg,
   output logic [3:0] rdr_fsize_reg,
   output logic [1:0] tr0_req_reg,
   output logic [1:0] tr1_req_reg,
   output logic [7:0] tr0_use_reg,
   output logic [7:0] tr1_use_reg,
   output logic sof_on_reg,
   output logic eof_on_reg
);
   import atc_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Reserved timing code folds onto the default
   function automatic logic [1:0] atc_tr_fix(input logic [1:0] code);
      atc_tr_fix = (code == `ATC_TR_RSVD) ? `ATC_TR_DEFAULT : code;
   endfunction

   function automatic logic atc_rate_ok(input logic [1:0] r);
      atc_rate_ok = (r == `ATC_RATE_106) || (r == `ATC_RATE_212);
   endfunction

   function automatic logic atc_fsize_ok(input logic [3:0] f);
      atc_fsize_ok = (f == 4'h8) || (f == 4'h7) || (f == 4'h6) || (f == 4'h5);
   endfunction

   // ----------------------------------------
   // Parser
   // ----------------------------------------
   atc_state_t state_reg;
   logic [3:0] cnt_reg;
   logic [31:0] ident_reg;
   logic [7:0] p1_reg, p2_reg, p3_reg, p4_reg;
   logic params_ok;
   logic frame_ok;

   // Byte counter and state; a new SOF always restarts the parse
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_reg <= ATC_IDLE;
         cnt_reg <= 4'h0;
      end
      else if (rx_sof)
      begin
         state_reg <= ATC_RECV;
         cnt_reg <= 4'h0;
      end
      else if (state_reg == ATC_RECV && rx_eof)
         state_reg <= ATC_DONE;
      else if (state_reg == ATC_RECV && rx_valid)
      begin
         if (cnt_reg == 4'h0 && rx_data != `ATC_CMD_CODE)
            state_reg <= ATC_SKIP; // [RULE_01]
         else if (cnt_reg != 4'hF)
            cnt_reg <= cnt_reg + 4'h1;
      end
      else if (state_reg == ATC_DONE || (state_reg == ATC_SKIP && rx_eof))
         state_reg <= ATC_IDLE;
   end

   // Capture identifier and parameter bytes by position
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ident_reg <= 32'h0000_0000;
         p1_reg <= 8'h00;
         p2_reg <= 8'h00;
         p3_reg <= 8'h00;
         p4_reg <= 8'h00;
      end
      else if (state_reg == ATC_RECV && rx_valid && !rx_eof)
      begin
         if (cnt_reg >= 4'h1 && cnt_reg <= 4'h4)
            ident_reg <= {ident_reg[23:0], rx_data}; // [RULE_01]
         if (cnt_reg == `ATC_POS_PARAM1)
            p1_reg <= rx_data;
         if (cnt_reg == `ATC_POS_PARAM2)
            p2_reg <= rx_data;
         if (cnt_reg == `ATC_POS_PARAM3)
            p3_reg <= rx_data;
         if (cnt_reg == `ATC_POS_PARAM4)
            p4_reg <= rx_data;
      end
   end

   // Validation; Param1 low bits and Param4 high nibble are ignored
   assign params_ok = (p2_reg[7:6] == p2_reg[5:4]) // [RULE_08]
      && atc_rate_ok(p2_reg[7:6]) && atc_fsize_ok(p2_reg[3:0]) // [RULE_10] [RULE_09]
      && (p3_reg == `ATC_PARAM3_OK) && (p3_reg[3:0] == `ATC_PROTO_TYPE) // [RULE_11] [RULE_14]
      && (p4_reg[3:0] == 4'h0); // [RULE_12]
   // Length is command plus ten bytes; CRC bytes are counted but checked upstream
   assign frame_ok = rx_crc_ok && (cnt_reg == `ATC_FRAME_LEN) // [RULE_13]
      && (ident_reg == pupi); // [RULE_16]

   // ----------------------------------------
   // Outcome
   // ----------------------------------------
   // Only an accepted frame touches state; rejections leave all as is
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cmd_enable_reg <= 1'b0;
         rate_reg <= `ATC_RATE_106;
         rdr_fsize_reg <= 4'h0;
         tr0_req_reg <= `ATC_TR_DEFAULT;
         tr1_req_reg <= `ATC_TR_DEFAULT;
      end
      else if (state_reg == ATC_RECV && rx_eof && frame_ok && params_ok)
      begin
         cmd_enable_reg <= 1'b1; // [RULE_02] [RULE_17]
         rate_reg <= p2_reg[7:6];
         rdr_fsize_reg <= p2_reg[3:0];
         tr0_req_reg <= atc_tr_fix(p1_reg[7:6]); // [RULE_03] [RULE_05]
         tr1_req_reg <= atc_tr_fix(p1_reg[5:4]); // [RULE_04] [RULE_05]
      end
   end

   // Reply strobe, one cycle per accepted frame
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         reply_req_reg <= 1'b0;
         reply_byte_reg <= 8'h00;
      end
      else
      begin
         reply_req_reg <= state_reg == ATC_RECV && rx_eof && frame_ok && params_ok;
         reply_byte_reg <= `ATC_REPLY_CODE; // [RULE_15]
      end
   end

   // Timing is fixed whatever the reader asks; omission bits are not honoured
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         tr0_use_reg <= 8'h00;
         tr1_use_reg <= 8'h00;
         sof_on_reg <= 1'b0;
         eof_on_reg <= 1'b0;
      end
      else
      begin
         tr0_use_reg <= `ATC_TR0_FIXED; // [RULE_06]
         tr1_use_reg <= `ATC_TR1_FIXED; // [RULE_06]
         sof_on_reg <= 1'b1; // [RULE_07]
         eof_on_reg <= 1'b1; // [RULE_07]
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   mismatch_silent_a: assert property (@(posedge clock) disable iff (rst) // [RULE_08]
      (state_reg == ATC_RECV && rx_eof && p2_reg[7:6] != p2_reg[5:4]) |=> !reply_req_reg)
      else $error("reply despite rate mismatch");
   bad_crc_a: assert property (@(posedge clock) disable iff (rst) // [RULE_13]
      (state_reg == ATC_RECV && rx_eof && !rx_crc_ok) |=> !reply_req_reg && $stable(cmd_enable_reg))
      else $error("acted on bad CRC");
   param3_a: assert property (@(posedge clock) disable iff (rst) // [RULE_11]
      (state_reg == ATC_RECV && rx_eof && p3_reg != 8'h01) |=> !reply_req_reg)
      else $error("reply with wrong Param3");
   param4_a: assert property (@(posedge clock) disable iff (rst) // [RULE_12]
      (state_reg == ATC_RECV && rx_eof && p4_reg[3:0] != 4'h0) |=> !reply_req_reg)
      else $error("reply with CID set");
   pupi_match_a: assert property (@(posedge clock) disable iff (rst) // [RULE_16]
      (state_reg == ATC_RECV && rx_eof && ident_reg != pupi) |=> !reply_req_reg)
      else $error("reply to other identifier");
   enable_on_reply_a: assert property (@(posedge clock) disable iff (rst) // [RULE_02]
      reply_req_reg |-> cmd_enable_reg && reply_byte_reg == 8'h10)
      else $error("reply without enable");
   rate_valid_a: assert property (@(posedge clock) disable iff (rst) // [RULE_10]
      reply_req_reg |-> rate_reg <= 2'h1 && rdr_fsize_reg >= 4'h5 && rdr_fsize_reg <= 4'h8)
      else $error("unsupported setting accepted");
   tr_fold_a: assert property (@(posedge clock) disable iff (rst) // [RULE_05]
      tr0_req_reg != 2'h3 && tr1_req_reg != 2'h3)
      else $error("reserved TR code kept");
   fixed_timing_a: assert property (@(posedge clock) disable iff (rst) // [RULE_06]
      $past(rst) == 1'b0 |-> tr0_use_reg == 8'h40 && tr1_use_reg == 8'h50 && sof_on_reg && eof_on_reg)
      else $error("timing not fixed");
endmodule
`default_nettype wire

// file: verif/atc_reader_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---
// Reader side of the link
// ---
module atc_reader_model
(
   // Clock
   input wire logic clock,
   // Byte stream toward the tag
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_sof,
   output logic rx_eof,
   output logic rx_crc_ok
);
   // Quiet lines at time zero
   initial
   begin
      {rx_valid, rx_sof, rx_eof, rx_crc_ok} = 4'h0;
      rx_data = 8'h00;
   end
   // Start pulse, 11 bytes, then end pulse with the CRC verdict
   // A short len drops trailing bytes, to build a frame of wrong length
   task automatic send(input logic [87:0] f, input logic crc, input int len = 11);
      @(posedge clock) #1 rx_sof = 1'b1;
      for (int i = 10; i > 10 - len; i--)
      begin
         @(posedge clock) #1 rx_sof = 1'b0;
         rx_valid = 1'b1;
         rx_data = f[i*8 +: 8];
      end
      @(posedge clock) #1 {rx_valid, rx_eof, rx_crc_ok} = {1'b0, 1'b1, crc};
      rx_data = ~rx_data; // Stale byte must not look held
      @(posedge clock) #1 {rx_eof, rx_crc_ok} = 2'b00;
   endtask
endmodule
`default_nettype wire

// file: verif/tb_atc_attrib_handler.sv
`timescale 1ns/1ns
`default_nettype none
module tb_atc_attrib_handler;
   localparam logic [31:0] PUPI_ID = 32'hA5C3_0F96;
   // ---
   // Wiring
   // ---
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic rx_valid, rx_sof, rx_eof, rx_crc_ok, cmd_enable_reg, reply_req_reg, sof_on_reg, eof_on_reg;
   logic [7:0] rx_data, reply_byte_reg, tr0_use_reg, tr1_use_reg;
   logic [1:0] rate_reg, tr0_req_reg, tr1_req_reg;
   logic [3:0] rdr_fsize_reg;
   logic [9:0] exp_set = 10'h000;
   logic exp_en = 1'b0;
   int n_mismatch = 0;
   int n_tests = 0;
   atc_reader_model atc_reader_model_inst (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok));
   atc_attrib_handler atc_attrib_handler_inst (.clock(clock), .rst(rst), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .pupi(PUPI_ID),
      .cmd_enable_reg(cmd_enable_reg), .reply_req_reg(reply_req_reg), .reply_byte_reg(reply_byte_reg),
      .rate_reg(rate_reg), .rdr_fsize_reg(rdr_fsize_reg), .tr0_req_reg(tr0_req_reg),
      .tr1_req_reg(tr1_req_reg), .tr0_use_reg(tr0_use_reg), .tr1_use_reg(tr1_use_reg),
      .sof_on_reg(sof_on_reg), .eof_on_reg(eof_on_reg));
   // Clock
   initial
   begin
      forever #2 clock = ~clock;
   end
   // ---
   // Checking helpers
   // ---
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Reserved timing code reads as the default one
   function automatic logic [1:0] fold(input logic [1:0] c);
      return (c === 2'b11) ? 2'b00 : c;
   endfunction
   // One frame, then the pulse, the held state and the fixed settings are judged
   task automatic attempt(input logic [7:0] cmd, p1, p2, p3, p4, input logic [31:0] id, input logic crc,
      input logic acc, input int len = 11);
      atc_reader_model_inst.send({cmd, id, p1, p2, p3, p4, 16'h0000}, crc, len);
      if (acc)
      begin
         exp_set = {p2[7:6], p2[3:0], fold(p1[7:6]), fold(p1[5:4])};
         exp_en = 1'b1;
      end
      chk("reply_req", {15'h0000, acc}, {15'h0000, reply_req_reg});
      chk("cmd_enable", {15'h0000, exp_en}, {15'h0000, cmd_enable_reg});
      chk("settings", {6'h00, exp_set}, {6'h00, rate_reg, rdr_fsize_reg, tr0_req_reg, tr1_req_reg});
      chk("tr_use", 16'h4050, {tr0_use_reg, tr1_use_reg});
      chk("delims", 16'h0003, {14'h0000, sof_on_reg, eof_on_reg});
      chk("reply_byte", 16'h0010, {8'h00, reply_byte_reg});
      // Reply strobe must be gone one cycle later
      @(posedge clock) #1;
      chk("reply_once", 16'h0000, {15'h0000, reply_req_reg});
   endtask
   // ---
   // Scenarios
   // ---
   task automatic t_ident();
      attempt(8'h1D, 8'h00, 8'h08, 8'h01, 8'h00, ~PUPI_ID, 1'b1, 1'b0);
      attempt(8'h05, 8'h00, 8'h08, 8'h01, 8'h00, PUPI_ID, 1'b1, 1'b0);
      attempt(8'h1D, 8'h00, 8'h08, 8'h01, 8'h00, PUPI_ID, 1'b0, 1'b0);
      attempt(8'h1D, 8'h00, 8'h08, 8'h01, 8'h00, PUPI_ID, 1'b1, 1'b0, 10);
      $display("t_ident done");
   endtask
   task automatic t_param1();
      attempt(8'h1D, 8'hFF, 8'h58, 8'h01, 8'h00, PUPI_ID, 1'b1, 1'b1);
      attempt(8'h1D, 8'h90, 8'h08, 8'h01, 8'h00, PUPI_ID, 1'b1, 1'b1);
      attempt(8'h1D, 8'h6C, 8'h57, 8'h01, 8'h00, PUPI_ID, 1'b1, 1'b1);
      $display("t_param1 done");
   endtask
   task automatic t_param2();
      attempt(8'h1D, 8'h00, 8'h48, 8'h01, 8'h00, PUPI_ID, 1'b1, 1'b0);
      attempt(8'h1D, 8'h00, 8'h18, 8'h01, 8'h00, PUPI_ID, 1'b1, 1'b0);
      attempt(8'h1D, 8'h00, 8'hA8, 8'h01, 8'h00, PUPI_ID, 1'b1, 1'b0);
      for (int f = 4; f <= 9; f++)
         attempt(8'h1D, 8'h00, 8'(f), 8'h01, 8'h00, PUPI_ID, 1'b1, 1'(f >= 5 && f <= 8));
      $display("t_param2 done");
   endtask
   task automatic t_param34();
      attempt(8'h1D, 8'h00, 8'h56, 8'h11, 8'h00, PUPI_ID, 1'b1, 1'b0);
      attempt(8'h1D, 8'h00, 8'h56, 8'h02, 8'h00, PUPI_ID, 1'b1, 1'b0);
      attempt(8'h1D, 8'h00, 8'h56, 8'h01, 8'hF0, PUPI_ID, 1'b1, 1'b1);
      attempt(8'h1D, 8'h00, 8'h08, 8'h01, 8'h08, PUPI_ID, 1'b1, 1'b0);
      $display("t_param34 done");
   endtask
   // Reset in mid-run clears the protocol state; frames right after it are judged afresh
   task automatic t_reset();
      @(posedge clock) #1 rst = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("mid_rst", 16'h0000, {5'h00, cmd_enable_reg, rate_reg, rdr_fsize_reg, tr0_req_reg, tr1_req_reg});
      rst = 1'b0;
      exp_en = 1'b0;
      exp_set = 10'h000;
      attempt(8'h1D, 8'h00, 8'h08, 8'h02, 8'h00, PUPI_ID, 1'b1, 1'b0);
      attempt(8'h1D, 8'hC0, 8'h55, 8'h01, 8'h00, PUPI_ID, 1'b1, 1'b1);
      $display("t_reset done");
   endtask
   // ---
   // Verdict and run
   // ---
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog, far beyond the roughly 340 cycles of traffic
   initial
   begin
      #20000;
      n_mismatch++;
      finish_test();
   end
   initial
   begin
      repeat (10) @(posedge clock);
      #1 chk("reset", 16'h0000, {tr0_use_reg, tr1_use_reg});
      chk("reset_ctl", 16'h0000, {12'h000, cmd_enable_reg, reply_req_reg, sof_on_reg, eof_on_reg});
      chk("reset_byte", 16'h0000, {8'h00, reply_byte_reg});
      rst = 1'b0;
      t_ident();
      t_param1();
      t_param2();
      t_param34();
      t_reset();
      finish_test();
   end
endmodule
`default_nettype wire
